// *** lsw_consts.svh ***
`ifndef LSW_CONSTS_SVH
`define LSW_CONSTS_SVH

// System clock in MHz
`define LSW_CLK_MHZ 125
// Watchdog oscillator period with the default timing resistor, in ns
`define LSW_OSC_PERIOD_NS 19615
// Initial lead time in ms
`define LSW_LEAD_TIME_MS 155
// Clock cycles per oscillator period, rounded down
`define LSW_OSC_DIV ((`LSW_OSC_PERIOD_NS * `LSW_CLK_MHZ) / 1000)
// Oscillator periods in the lead time, rounded down
`define LSW_LEAD_TICKS ((`LSW_LEAD_TIME_MS * 1000000) / `LSW_OSC_PERIOD_NS)
// Closed and open window and reset hold, in oscillator periods
`define LSW_CLOSED_TICKS 1000
`define LSW_OPEN_TICKS 1000
`define LSW_RST_TICKS 200
// Counter width for all watchdog intervals
`define LSW_CNT_W 16
// Reset values
`define LSW_TRIG_RST 1'b1
`define LSW_RXD_RST 1'b1

`endif

// *** lsw_pkg.sv ***
`default_nettype none
package lsw_pkg;
  typedef enum logic [1:0] {
    LSW_FAILSAFE,
    LSW_NORMAL,
    LSW_SILENT,
    LSW_SLEEP
  } lsw_mode_t;

  typedef enum logic [2:0] {
    LSW_WD_OFF,
    LSW_WD_LEAD,
    LSW_WD_CLOSED,
    LSW_WD_OPEN,
    LSW_WD_RESET
  } lsw_wd_t;

  typedef struct packed {
    logic o;
    logic oe;
  } lsw_od_pin_t;
endpackage
`default_nettype wire

// *** lsw_wd_mode.sv ***
`timescale 1ns/1ns
`include "lsw_consts.svh"
`default_nettype none

module lsw_wd_mode #(
  parameter int OSC_DIV = `LSW_OSC_DIV,
  parameter int LEAD_TICKS = `LSW_LEAD_TICKS,
  parameter int CLOSED_TICKS = `LSW_CLOSED_TICKS,
  parameter int OPEN_TICKS = `LSW_OPEN_TICKS,
  parameter int RST_TICKS = `LSW_RST_TICKS
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic en_in,
  input wire logic sleep_req,
  input wire logic wake_in,
  input wire logic undervoltage_in,
  input wire logic debug_mode_in,
  input wire logic wd_trigger_in_n,
  input wire logic txd_in,
  input wire logic lin_bus_in,
  output lsw_pkg::lsw_od_pin_t lin_bus_pin,
  output logic rxd_out,
  output lsw_pkg::lsw_od_pin_t sys_reset_out_n,
  output lsw_pkg::lsw_mode_t mode,
  output lsw_pkg::lsw_wd_t wd_phase
);
  import lsw_pkg::*;

  localparam int CW = `LSW_CNT_W;

  generate
    if (OSC_DIV < 1 || OSC_DIV >= (1 << CW) || LEAD_TICKS < 1 || LEAD_TICKS >= (1 << CW) ||
        CLOSED_TICKS < 1 || CLOSED_TICKS >= (1 << CW) || OPEN_TICKS < 1 ||
        OPEN_TICKS >= (1 << CW) || RST_TICKS < 1 || RST_TICKS >= (1 << CW)) begin : g_bad
      $error("lsw_wd_mode: interval parameter out of range");
    end
  endgenerate

  function automatic logic [CW-1:0] wd_limit(input lsw_wd_t st);
    case (st)
      LSW_WD_LEAD: wd_limit = CW'(LEAD_TICKS - 1);
      LSW_WD_CLOSED: wd_limit = CW'(CLOSED_TICKS - 1);
      LSW_WD_OPEN: wd_limit = CW'(OPEN_TICKS - 1);
      LSW_WD_RESET: wd_limit = CW'(RST_TICKS - 1);
      default: wd_limit = '0;
    endcase
  endfunction

  lsw_mode_t mode_q;
  lsw_mode_t mode_d;
  lsw_wd_t wd_q;
  lsw_wd_t wd_d;
  logic [CW-1:0] pre_q;
  logic [CW-1:0] cnt_q;
  logic trig_prev_q;
  logic rxd_q;
  lsw_od_pin_t lin_q;
  lsw_od_pin_t rst_line_q;

  wire osc_tick = clk_en && (pre_q == CW'(OSC_DIV - 1));
  wire phase_end = osc_tick && (cnt_q == wd_limit(wd_q));
  wire trig_fall = clk_en && trig_prev_q && !wd_trigger_in_n;
  // Watchdog idle outside normal and fail-safe
  wire wd_run = (mode_q == LSW_NORMAL || mode_q == LSW_FAILSAFE) && !debug_mode_in;
  wire rst_d = (wd_d == LSW_WD_RESET) || undervoltage_in;
  wire pass_d = (mode_d == LSW_NORMAL) && !rst_d;

  always_comb begin
    wd_d = wd_q;
    if (!wd_run) begin
      wd_d = LSW_WD_OFF;
    end else begin
      case (wd_q)
        LSW_WD_OFF: wd_d = LSW_WD_LEAD;
        LSW_WD_LEAD: begin
          if (trig_fall) begin
            wd_d = LSW_WD_CLOSED;
          end else if (phase_end) begin
            wd_d = LSW_WD_RESET;
          end
        end
        LSW_WD_CLOSED: begin
          if (trig_fall) begin
            wd_d = LSW_WD_RESET;
          end else if (phase_end) begin
            wd_d = LSW_WD_OPEN;
          end
        end
        LSW_WD_OPEN: begin
          if (trig_fall) begin
            wd_d = LSW_WD_CLOSED;
          end else if (phase_end) begin
            wd_d = LSW_WD_RESET;
          end
        end
        LSW_WD_RESET: begin
          if (phase_end) begin
            wd_d = LSW_WD_LEAD;
          end
        end
        default: wd_d = LSW_WD_OFF;
      endcase
    end
  end

  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      LSW_FAILSAFE: begin
        if (en_in && !rst_d) begin
          mode_d = LSW_NORMAL;
        end
      end
      LSW_NORMAL: begin
        // Failure or undervoltage drops to fail-safe
        if (rst_d) begin
          mode_d = LSW_FAILSAFE;
        end else if (!en_in) begin
          mode_d = sleep_req ? LSW_SLEEP : LSW_SILENT;
        end
      end
      LSW_SILENT, LSW_SLEEP: begin
        if (wake_in) begin
          mode_d = LSW_FAILSAFE;
        end
      end
      default: mode_d = LSW_FAILSAFE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      mode_q <= LSW_FAILSAFE;
      wd_q <= LSW_WD_OFF;
      pre_q <= '0;
      cnt_q <= '0;
      trig_prev_q <= `LSW_TRIG_RST;
    end else if (clk_en) begin
      mode_q <= mode_d;
      wd_q <= wd_d;
      pre_q <= osc_tick ? '0 : pre_q + 1'b1;
      cnt_q <= (wd_d != wd_q) ? '0 : (osc_tick ? cnt_q + 1'b1 : cnt_q);
      trig_prev_q <= wd_trigger_in_n;
    end
  end

  // Pin stages; power-up reset holds the reset line low
  always_ff @(posedge clock) begin
    if (reset) begin
      rxd_q <= `LSW_RXD_RST;
      lin_q <= '0;
      rst_line_q <= '{o: 1'b0, oe: 1'b1};
    end else if (clk_en) begin
      lin_q <= '{o: 1'b0, oe: pass_d && !txd_in};
      rxd_q <= pass_d ? lin_bus_in : 1'b1;
      rst_line_q <= '{o: 1'b0, oe: rst_d};
    end
  end

  assign lin_bus_pin = lin_q;
  assign rxd_out = rxd_q;
  assign sys_reset_out_n = rst_line_q;
  assign mode = mode_q;
  assign wd_phase = wd_q;

  chk_powerup_mode: assert property (@(posedge clock) reset |=> mode_q == LSW_FAILSAFE)
    else $error("mode not fail-safe after reset");
  chk_failsafe_hold: assert property (@(posedge clock) disable iff (reset)
    mode_q == LSW_FAILSAFE && !en_in |=> mode_q == LSW_FAILSAFE)
    else $error("left fail-safe without enable");
  chk_enable_normal: assert property (@(posedge clock) disable iff (reset)
    clk_en && mode_q == LSW_FAILSAFE && en_in && !rst_d |=> mode_q == LSW_NORMAL)
    else $error("enable did not enter normal");
  chk_open_miss: assert property (@(posedge clock) disable iff (reset)
    clk_en && wd_run && wd_q == LSW_WD_OPEN && phase_end && !trig_fall
    |=> wd_q == LSW_WD_RESET && !sys_reset_out_n.o && sys_reset_out_n.oe)
    else $error("missed open window gave no reset");
  chk_early_trig: assert property (@(posedge clock) disable iff (reset)
    clk_en && wd_run && wd_q == LSW_WD_CLOSED && trig_fall |=> sys_reset_out_n.oe)
    else $error("early trigger gave no reset");
  chk_lead_expiry: assert property (@(posedge clock) disable iff (reset)
    clk_en && wd_run && wd_q == LSW_WD_LEAD && phase_end && !trig_fall |=> wd_q == LSW_WD_RESET)
    else $error("lead expiry gave no reset");
  chk_low_power_off: assert property (@(posedge clock) disable iff (reset)
    clk_en && (mode_q == LSW_SILENT || mode_q == LSW_SLEEP) |=> wd_q == LSW_WD_OFF)
    else $error("watchdog running in low power mode");
  chk_gate_normal: assert property (@(posedge clock) disable iff (reset)
    (lin_bus_pin.oe || !rxd_out) |-> mode_q == LSW_NORMAL && !sys_reset_out_n.oe)
    else $error("transceiver active outside normal");
  chk_tx_follow: assert property (@(posedge clock) disable iff (reset)
    clk_en && pass_d |=> lin_bus_pin.oe == !$past(txd_in))
    else $error("bus does not follow transmit");
  chk_rx_follow: assert property (@(posedge clock) disable iff (reset)
    clk_en && pass_d |=> rxd_out == $past(lin_bus_in))
    else $error("receive does not follow bus");
  chk_debug_off: assert property (@(posedge clock) disable iff (reset)
    clk_en && debug_mode_in |=> wd_q == LSW_WD_OFF)
    else $error("watchdog active in debug mode");
  chk_fail_safe: assert property (@(posedge clock) disable iff (reset)
    sys_reset_out_n.oe |-> mode_q != LSW_NORMAL)
    else $error("normal mode during reset");
  chk_restart_lead: assert property (@(posedge clock) disable iff (reset)
    clk_en && wd_run && wd_q == LSW_WD_RESET && phase_end |=> wd_q == LSW_WD_LEAD)
    else $error("no restart from lead");
  chk_freeze_state: assert property (@(posedge clock) disable iff (reset)
    !clk_en |=> $stable(wd_q) && $stable(mode_q) && $stable(cnt_q))
    else $error("state moved with clock enable low");

  cov_enter_normal: cover property (@(posedge clock) disable iff (reset)
    mode_q == LSW_FAILSAFE ##1 mode_q == LSW_NORMAL);
  cov_good_trigger: cover property (@(posedge clock) disable iff (reset)
    wd_q == LSW_WD_OPEN && trig_fall);
  cov_wd_reset: cover property (@(posedge clock) disable iff (reset)
    wd_q != LSW_WD_RESET ##1 wd_q == LSW_WD_RESET);
  cov_sleep: cover property (@(posedge clock) disable iff (reset)
    mode_q == LSW_NORMAL ##1 mode_q == LSW_SLEEP);
endmodule

`default_nettype wire

// *** lsw_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module lsw_host_model (
  input wire logic fire,
  output logic wd_trigger_in_n
);
  assign wd_trigger_in_n = !fire;
endmodule
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb;
  import lsw_pkg::*;
  logic clock, reset, clk_en, en_in, sleep_req, wake_in, uv, dbg, txd_in, bus_n, fire;
  logic trig_n, rxd_out, lin_bus_in;
  lsw_od_pin_t lin_bus_pin, sys_reset_out_n;
  lsw_mode_t mode;
  lsw_wd_t wd_phase;
  int n_errors = 0;
  int n_compared = 0;
  int n;
  // Pull-up wire, dominant if either side pulls
  assign lin_bus_in = !lin_bus_pin.oe && bus_n;
  lsw_wd_mode #(.OSC_DIV(2), .LEAD_TICKS(20), .CLOSED_TICKS(8), .OPEN_TICKS(8), .RST_TICKS(4)) u_lsw_wd_mode (
    .clock(clock), .reset(reset), .clk_en(clk_en), .en_in(en_in), .sleep_req(sleep_req), .wake_in(wake_in),
    .undervoltage_in(uv), .debug_mode_in(dbg), .wd_trigger_in_n(trig_n), .txd_in(txd_in),
    .lin_bus_in(lin_bus_in), .lin_bus_pin(lin_bus_pin), .rxd_out(rxd_out), .sys_reset_out_n(sys_reset_out_n),
    .mode(mode), .wd_phase(wd_phase));
  lsw_host_model u_lsw_host_model (.fire(fire), .wd_trigger_in_n(trig_n));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  task automatic conclude();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clock);
  endtask
  task automatic wait_ph(input lsw_wd_t p, input int lim);
    n = 0;
    while (wd_phase !== p && n < lim) begin
      cyc(1);
      n++;
    end
    if (n >= lim) begin
      n_errors++;
      $display("wrong value at %0t: phase wait ran out", $time);
      conclude();
    end
  endtask
  task automatic rst();
    reset = 1'b1;
    clk_en = 1'b1;
    {en_in, sleep_req, wake_in, uv, dbg, fire} = 6'h00;
    {txd_in, bus_n} = 2'h3;
    cyc(8);
    reset = 1'b0;
  endtask
  task automatic trig();
    fire = 1'b1;
    cyc(1);
    fire = 1'b0;
  endtask
  task automatic t_lead();
    rst();
    cyc(4);
    chk(mode, LSW_FAILSAFE);
    chk(sys_reset_out_n.oe, 1'b0);
    wait_ph(LSW_WD_RESET, 60);
    chk(n >= 34 && n <= 42, 1'b1);
    chk(sys_reset_out_n.oe, 1'b1);
    chk(sys_reset_out_n.o, 1'b0);
    wait_ph(LSW_WD_LEAD, 20);
    chk(n >= 6 && n <= 10, 1'b1);
    chk(sys_reset_out_n.oe, 1'b0);
    $display("lead test done");
  endtask
  task automatic t_freeze();
    rst();
    cyc(4);
    // Lead would expire within 60 cycles if the enable did not freeze it
    clk_en = 1'b0;
    cyc(60);
    chk(wd_phase, LSW_WD_LEAD);
    chk(sys_reset_out_n.oe, 1'b0);
    clk_en = 1'b1;
    wait_ph(LSW_WD_RESET, 60);
    chk(n >= 34 && n <= 40, 1'b1);
    $display("freeze test done");
  endtask
  task automatic t_window();
    rst();
    cyc(4);
    trig();
    chk(wd_phase, LSW_WD_CLOSED);
    wait_ph(LSW_WD_OPEN, 24);
    trig();
    chk(wd_phase, LSW_WD_CLOSED);
    cyc(2);
    trig();
    chk(wd_phase, LSW_WD_RESET);
    chk(sys_reset_out_n.oe, 1'b1);
    wait_ph(LSW_WD_LEAD, 20);
    trig();
    wait_ph(LSW_WD_OPEN, 24);
    wait_ph(LSW_WD_RESET, 24);
    chk(n >= 14 && n <= 18, 1'b1);
    $display("window test done");
  endtask
  task automatic t_normal();
    rst();
    txd_in = 1'b0;
    cyc(2);
    chk(lin_bus_pin.oe, 1'b0);
    en_in = 1'b1;
    cyc(1);
    chk(mode, LSW_NORMAL);
    cyc(1);
    chk(lin_bus_pin.oe, 1'b1);
    chk(lin_bus_pin.o, 1'b0);
    txd_in = 1'b1;
    cyc(1);
    chk(lin_bus_pin.oe, 1'b0);
    bus_n = 1'b0;
    cyc(1);
    chk(rxd_out, 1'b0);
    bus_n = 1'b1;
    cyc(1);
    chk(rxd_out, 1'b1);
    uv = 1'b1;
    txd_in = 1'b0;
    cyc(2);
    chk(sys_reset_out_n.oe, 1'b1);
    chk(mode, LSW_FAILSAFE);
    chk(lin_bus_pin.oe, 1'b0);
    uv = 1'b0;
    cyc(2);
    chk(mode, LSW_NORMAL);
    $display("normal test done");
  endtask
  task automatic t_modes();
    rst();
    en_in = 1'b1;
    cyc(2);
    en_in = 1'b0;
    cyc(2);
    chk(mode, LSW_SILENT);
    chk(wd_phase, LSW_WD_OFF);
    txd_in = 1'b0;
    cyc(60);
    chk(lin_bus_pin.oe, 1'b0);
    chk(sys_reset_out_n.oe, 1'b0);
    txd_in = 1'b1;
    wake_in = 1'b1;
    cyc(2);
    wake_in = 1'b0;
    en_in = 1'b1;
    cyc(2);
    sleep_req = 1'b1;
    en_in = 1'b0;
    cyc(2);
    chk(mode, LSW_SLEEP);
    chk(wd_phase, LSW_WD_OFF);
    rst();
    dbg = 1'b1;
    cyc(60);
    chk(wd_phase, LSW_WD_OFF);
    chk(sys_reset_out_n.oe, 1'b0);
    uv = 1'b1;
    cyc(2);
    chk(sys_reset_out_n.oe, 1'b1);
    $display("mode test done");
  endtask
  initial begin
    rst();
    t_lead();
    t_freeze();
    t_window();
    t_normal();
    t_modes();
    conclude();
  end
endmodule
`default_nettype wire
